//--- design/spo_pkg.sv
package spo_pkg;
	// register addresses, lower 16 bits
	localparam logic [15:0] SPO_ADDR_IN_CTRL = 16'hfffc;
	localparam logic [15:0] SPO_ADDR_OUT_CTRL = 16'hfffd;
	localparam logic [7:0] SPO_IN_CTRL_RESET = 8'h00;
	localparam logic [7:0] SPO_OUT_CTRL_RESET = 8'h00;
	localparam logic [7:0] SPO_RDATA_IDLE = 8'h00;

	// input control fields
	localparam int unsigned SPO_BIT_VERT_IN_INV = 0;
	localparam int unsigned SPO_BIT_HORIZ_IN_INV = 1;
	localparam int unsigned SPO_BIT_SPARE_VERT_IN_INV = 2;
	localparam int unsigned SPO_BIT_SPARE_HORIZ_IN_INV = 3;
	localparam int unsigned SPO_BIT_SYNC_CONN_EN = 5;

	// output control fields
	localparam int unsigned SPO_BIT_BLANK_OUT_INV = 0;
	localparam int unsigned SPO_BIT_CLAMP_OUT_INV = 1;
	localparam int unsigned SPO_BIT_VERT_OUT_INV = 2;
	localparam int unsigned SPO_BIT_HORIZ_OUT_INV = 3;
	localparam int unsigned SPO_BIT_BLANK_OUT_EN = 4;
	localparam int unsigned SPO_BIT_CLAMP_OUT_EN = 5;
	localparam int unsigned SPO_BIT_VERT_OUT_EN = 6;
	localparam int unsigned SPO_BIT_HORIZ_OUT_EN = 7;

	// operating modes
	localparam logic [1:0] SPO_MODE_EXP_NOROM = 2'h1;

	typedef struct packed {
		logic spare_horiz;
		logic spare_vert;
		logic composite;
		logic horiz;
		logic vert;
	} spo_sync_in_t;

	typedef struct packed {
		logic horiz;
		logic vert;
		logic clamp;
		logic blank;
	} spo_sync_src_t;
endpackage

//--- design/spo_invert.sv
`timescale 1ns/1ps
`default_nettype none
module spo_invert #(
	parameter int WIDTH = 4
) (
	// data and per-bit invert select
	input wire logic [WIDTH-1:0] din,
	input wire logic [WIDTH-1:0] inv,
	output logic [WIDTH-1:0] dout
);
	assign dout = din ^ inv;
endmodule
`default_nettype wire

//--- design/spo_sync_polarity_output_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
//Behaviour
// - spare vertical input inverted by bit 2
// - bit 1 inverts horizontal and composite inputs
// - vertical input inverted by bit 0
// - output register 8-bit rw, cleared reset/standby
// - disabled output leaves pin to port/timer
// - output enables never touch input functions
// - bit 7 puts horizontal sync on pin
// - bit 6 puts vertical sync on pin
// - bit 5 puts clamp wave on pin
// - blank enable in mode 1 gives address
// - blank enable in modes 2/3 drives blank
// - bit 3 inverts horizontal output
// - bit 2 inverts vertical output
// - bit 1 inverts selected clamp source
// - bit 0 inverts blanking output
// - spare horizontal input inverted by bit 3
module spo_sync_polarity_output_ctrl
	import spo_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic hw_standby,
	// chip mode
	input wire logic [1:0] op_mode,
	input wire logic host_interface_enable,
	// register port
	input wire logic [15:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	// input sync pins and internal results
	input wire spo_sync_in_t sync_pins_in,
	output spo_sync_in_t sync_in_int,
	output logic sync_connection_enable,
	output logic [7:0] sync_input_connect_ctrl,
	// internal output sources
	input wire spo_sync_src_t sync_src,
	// alternate pin functions
	input wire spo_sync_src_t alt_out,
	input wire spo_sync_src_t alt_oe,
	input wire logic address_bit_fifteen,
	// shared output pins
	output spo_sync_src_t pin_out,
	output spo_sync_src_t pin_oe
);
	logic [7:0] sync_output_connect_ctrl;
	logic acc_ok;
	logic [4:0] in_inv;
	logic [4:0] in_raw;
	logic [4:0] in_fix;
	logic [3:0] out_raw;
	logic [3:0] out_fix;
	spo_sync_src_t wave;
	logic blank_is_addr;

	assign acc_ok = !host_interface_enable;

	// register file
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_input_connect_ctrl <= SPO_IN_CTRL_RESET;
		end else if (hw_standby) begin
			sync_input_connect_ctrl <= SPO_IN_CTRL_RESET;
		end else if (reg_wr && acc_ok && reg_addr == SPO_ADDR_IN_CTRL) begin
			sync_input_connect_ctrl <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			sync_output_connect_ctrl <= SPO_OUT_CTRL_RESET;
		end else if (hw_standby) begin
			sync_output_connect_ctrl <= SPO_OUT_CTRL_RESET;
		end else if (reg_wr && acc_ok && reg_addr == SPO_ADDR_OUT_CTRL) begin
			sync_output_connect_ctrl <= reg_wdata;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= SPO_RDATA_IDLE;
		end else if (!(reg_rd && acc_ok)) begin
			reg_rdata <= SPO_RDATA_IDLE;
		end else if (reg_addr == SPO_ADDR_IN_CTRL) begin
			reg_rdata <= sync_input_connect_ctrl;
		end else if (reg_addr == SPO_ADDR_OUT_CTRL) begin
			reg_rdata <= sync_output_connect_ctrl;
		end else begin
			reg_rdata <= SPO_RDATA_IDLE;
		end
	end

	assign sync_connection_enable = sync_input_connect_ctrl[SPO_BIT_SYNC_CONN_EN];

	// input polarity
	assign in_inv = {
		sync_input_connect_ctrl[SPO_BIT_SPARE_HORIZ_IN_INV],
		sync_input_connect_ctrl[SPO_BIT_SPARE_VERT_IN_INV],
		sync_input_connect_ctrl[SPO_BIT_HORIZ_IN_INV],
		sync_input_connect_ctrl[SPO_BIT_HORIZ_IN_INV],
		sync_input_connect_ctrl[SPO_BIT_VERT_IN_INV]
	};
	assign in_raw = sync_pins_in;
	assign sync_in_int = in_fix;

	spo_invert #(.WIDTH(5)) u_in_inv (
		.din(in_raw),
		.inv(in_inv),
		.dout(in_fix)
	);

	// output polarity
	assign out_raw = sync_src;
	assign wave = out_fix;

	spo_invert #(.WIDTH(4)) u_out_inv (
		.din(out_raw),
		.inv(sync_output_connect_ctrl[SPO_BIT_HORIZ_OUT_INV:SPO_BIT_BLANK_OUT_INV]),
		.dout(out_fix)
	);

	assign blank_is_addr = (op_mode == SPO_MODE_EXP_NOROM);

	// pin multiplexing
	always_comb begin
		pin_out = alt_out;
		pin_oe = alt_oe;
		if (sync_output_connect_ctrl[SPO_BIT_HORIZ_OUT_EN]) begin
			pin_out.horiz = wave.horiz;
			pin_oe.horiz = 1'b1;
		end
		if (sync_output_connect_ctrl[SPO_BIT_VERT_OUT_EN]) begin
			pin_out.vert = wave.vert;
			pin_oe.vert = 1'b1;
		end
		if (sync_output_connect_ctrl[SPO_BIT_CLAMP_OUT_EN]) begin
			pin_out.clamp = wave.clamp;
			pin_oe.clamp = 1'b1;
		end
		if (sync_output_connect_ctrl[SPO_BIT_BLANK_OUT_EN]) begin
			pin_oe.blank = 1'b1;
			if (blank_is_addr) begin
				pin_out.blank = address_bit_fifteen;
			end else begin
				pin_out.blank = wave.blank;
			end
		end
	end

	// checks
	sequence s_out_write;
		reg_wr && acc_ok && reg_addr == SPO_ADDR_OUT_CTRL && !hw_standby;
	endsequence
	sequence s_out_read;
		reg_rd && acc_ok && reg_addr == SPO_ADDR_OUT_CTRL && !reg_wr && !hw_standby;
	endsequence

	AST_OUT_REG_RW: assert property (@(posedge sys_clk) disable iff (!reset_n)
		s_out_write ##1 s_out_read |=> reg_rdata == $past(reg_wdata, 2))
		else $error("output control readback mismatch");
	AST_STANDBY_CLR: assert property (@(posedge sys_clk) disable iff (!reset_n)
		hw_standby |=> sync_output_connect_ctrl == SPO_OUT_CTRL_RESET)
		else $error("standby did not clear output control");
	AST_HIE_BLOCK: assert property (@(posedge sys_clk) disable iff (!reset_n)
		host_interface_enable && !hw_standby |=> $stable(sync_output_connect_ctrl))
		else $error("register changed while host interface enabled");
	AST_VERT_IN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_in_int.vert == (sync_pins_in.vert ^ sync_input_connect_ctrl[SPO_BIT_VERT_IN_INV]))
		else $error("vertical input polarity wrong");
	AST_HORIZ_IN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_in_int.horiz ==
		(sync_pins_in.horiz ^ sync_input_connect_ctrl[SPO_BIT_HORIZ_IN_INV]) &&
		sync_in_int.composite ==
		(sync_pins_in.composite ^ sync_input_connect_ctrl[SPO_BIT_HORIZ_IN_INV]))
		else $error("horizontal or composite input polarity wrong");
	AST_SPARE_VERT_IN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_in_int.spare_vert ==
		(sync_pins_in.spare_vert ^ sync_input_connect_ctrl[SPO_BIT_SPARE_VERT_IN_INV]))
		else $error("spare vertical input polarity wrong");
	AST_SPARE_HORIZ_IN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_in_int.spare_horiz ==
		(sync_pins_in.spare_horiz ^ sync_input_connect_ctrl[SPO_BIT_SPARE_HORIZ_IN_INV]))
		else $error("spare horizontal input polarity wrong");
	AST_HORIZ_PIN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_output_connect_ctrl[SPO_BIT_HORIZ_OUT_EN] |-> pin_oe.horiz &&
		pin_out.horiz == (sync_src.horiz ^ sync_output_connect_ctrl[SPO_BIT_HORIZ_OUT_INV]))
		else $error("horizontal sync pin wrong");
	AST_VERT_PIN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_output_connect_ctrl[SPO_BIT_VERT_OUT_EN] |-> pin_oe.vert &&
		pin_out.vert == (sync_src.vert ^ sync_output_connect_ctrl[SPO_BIT_VERT_OUT_INV]))
		else $error("vertical sync pin wrong");
	AST_CLAMP_PIN: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_output_connect_ctrl[SPO_BIT_CLAMP_OUT_EN] |-> pin_oe.clamp &&
		pin_out.clamp == (sync_src.clamp ^ sync_output_connect_ctrl[SPO_BIT_CLAMP_OUT_INV]))
		else $error("clamp pin wrong");
	AST_BLANK_MODE: assert property (@(posedge sys_clk) disable iff (!reset_n)
		sync_output_connect_ctrl[SPO_BIT_BLANK_OUT_EN] |-> pin_oe.blank &&
		pin_out.blank == ((op_mode == SPO_MODE_EXP_NOROM) ? address_bit_fifteen :
		(sync_src.blank ^ sync_output_connect_ctrl[SPO_BIT_BLANK_OUT_INV])))
		else $error("blank pin wrong");
	AST_ALT_PASS: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!sync_output_connect_ctrl[SPO_BIT_HORIZ_OUT_EN] |-> pin_out.horiz == alt_out.horiz &&
		pin_oe.horiz == alt_oe.horiz)
		else $error("disabled pin not left to alternate function");
	AST_ALT_PASS_VERT: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!sync_output_connect_ctrl[SPO_BIT_VERT_OUT_EN] |-> pin_out.vert == alt_out.vert &&
		pin_oe.vert == alt_oe.vert)
		else $error("disabled vertical pin not left to alternate function");
	AST_ALT_PASS_CLAMP: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!sync_output_connect_ctrl[SPO_BIT_CLAMP_OUT_EN] |-> pin_out.clamp == alt_out.clamp &&
		pin_oe.clamp == alt_oe.clamp)
		else $error("disabled clamp pin not left to alternate function");
	AST_ALT_PASS_BLANK: assert property (@(posedge sys_clk) disable iff (!reset_n)
		!sync_output_connect_ctrl[SPO_BIT_BLANK_OUT_EN] |-> pin_out.blank == alt_out.blank &&
		pin_oe.blank == alt_oe.blank)
		else $error("disabled blank pin not left to alternate function");
	AST_HIE_READ: assert property (@(posedge sys_clk) disable iff (!reset_n)
		host_interface_enable && reg_rd |=> reg_rdata == SPO_RDATA_IDLE)
		else $error("read answered while host interface enabled");
endmodule
`default_nettype wire

//--- sim/spo_sync_partner.sv
`timescale 1ns/1ps
`default_nettype none
module spo_sync_partner
	import spo_pkg::*;
(
	// bench clock
	input wire logic sys_clk,
	// sync pin levels
	output spo_sync_in_t sync_pins
);
	logic [4:0] lvl = 5'h13;
	// pins wander every cycle
	always @(negedge sys_clk) lvl <= {lvl[3:0], lvl[4] ^ lvl[2]};
	assign sync_pins = lvl;
endmodule
`default_nettype wire

//--- sim/sync_polarity_output_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
module sync_polarity_output_ctrl_bench;
	import spo_pkg::*;
	logic sys_clk = 0;
	logic reset_n = 0;
	logic hw_standby = 0;
	logic host_if_en = 0;
	logic reg_wr = 0;
	logic reg_rd = 0;
	logic addr_hi_bit = 0;
	logic sce;
	logic [1:0] op_mode = 2'h2;
	logic [15:0] reg_addr = 16'h0000;
	logic [7:0] reg_wdata = 8'h00;
	logic [7:0] reg_rdata;
	logic [7:0] ic_q;
	logic [16:0] rnd = 17'h18001;
	spo_sync_in_t pins;
	spo_sync_in_t ints;
	spo_sync_src_t src = 0;
	spo_sync_src_t alt_o = 0;
	spo_sync_src_t alt_e = 0;
	spo_sync_src_t p_out;
	spo_sync_src_t p_oe;
	int bad_count = 0;
	int total_checks = 0;
	int mi = 0;
	int mo = 0;
	always #5 sys_clk = ~sys_clk;
	spo_sync_partner far_end (.sys_clk(sys_clk), .sync_pins(pins));
	spo_sync_polarity_output_ctrl uut (.sys_clk(sys_clk), .reset_n(reset_n),
		.hw_standby(hw_standby), .op_mode(op_mode), .host_interface_enable(host_if_en),
		.reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata), .sync_pins_in(pins), .sync_in_int(ints),
		.sync_connection_enable(sce), .sync_input_connect_ctrl(ic_q), .sync_src(src),
		.alt_out(alt_o), .alt_oe(alt_e), .address_bit_fifteen(addr_hi_bit), .pin_out(p_out),
		.pin_oe(p_oe));
	function automatic logic [16:0] lfsr(input logic [16:0] v);
		return {v[15:0], v[16] ^ v[13]};
	endfunction
	task automatic chk(input string n, input logic [13:0] e, input logic [13:0] g);
		total_checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic chk_reg(input logic [7:0] e, input logic [7:0] g);
		chk("reg", {6'h0, e}, {6'h0, g});
	endtask
	task automatic chk_pins;
		logic [3:0] en;
		logic [3:0] eo;
		en = mo[7:4];
		eo = (en & (src ^ mo[3:0])) | (~en & alt_o);
		if (en[0] && op_mode == SPO_MODE_EXP_NOROM) eo[0] = addr_hi_bit;
		chk("pins", {1'b0, eo, en | alt_e, pins ^ {mi[3:1], mi[1:0]}},
			{1'b0, p_out, p_oe, ints});
		chk_reg({2'h0, mi[5], 5'h0}, {2'h0, sce, 5'h0});
		chk_reg(mi[7:0], ic_q);
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(negedge sys_clk);
		reg_wr = 0;
		if (!host_if_en && !hw_standby && a == SPO_ADDR_IN_CTRL) mi = d;
		if (!host_if_en && !hw_standby && a == SPO_ADDR_OUT_CTRL) mo = d;
	endtask
	task automatic rd_now(input logic [15:0] a);
		reg_addr = a;
		reg_rd = 1;
		@(negedge sys_clk);
		reg_rd = 0;
		chk_reg(host_if_en ? 8'h00 : a == SPO_ADDR_IN_CTRL ? mi[7:0] :
			a == SPO_ADDR_OUT_CTRL ? mo[7:0] : 8'h00, reg_rdata);
	endtask
	task automatic rd(input logic [15:0] a);
		@(negedge sys_clk);
		rd_now(a);
	endtask
	task automatic report_and_stop;
		$display("checks %0d errors %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (16) @(negedge sys_clk);
		reset_n = 1;
		rd(SPO_ADDR_IN_CTRL);
		rd(SPO_ADDR_OUT_CTRL);
		for (int i = 0; i < 400; i++) begin
			@(negedge sys_clk);
			rnd = lfsr(rnd);
			src = rnd[3:0];
			alt_o = rnd[7:4];
			alt_e = rnd[11:8];
			addr_hi_bit = rnd[12];
			op_mode = rnd[14:13];
			host_if_en = (rnd[16:15] == 2'h3);
			hw_standby = (i % 50 == 49);
			#1;
			chk_pins;
			wr(16'hfffc + rnd[1:0], rnd[16:9]);
			if (hw_standby) begin
				mi = 0;
				mo = 0;
			end
			hw_standby = 0;
			// read back in the very next cycle
			rd_now(16'hfffc + rnd[1:0]);
			if (i == 300) begin
				reset_n = 0;
				mi = 0;
				mo = 0;
				@(negedge sys_clk);
				reset_n = 1;
				rd(SPO_ADDR_OUT_CTRL);
			end
		end
		report_and_stop;
	end
endmodule
`default_nettype wire
